/* File: hw/cau_defines.svh */
`ifndef CAU_DEFINES_SVH
`define CAU_DEFINES_SVH

// register byte addresses
`define CAU_ADDR_CTRL 8'h00
`define CAU_ADDR_ACCFLG 8'h04
`define CAU_ADDR_OPERAND 8'h08
`define CAU_ADDR_PAIRS 8'h0C
`define CAU_ADDR_PTRSTK 8'h10
`define CAU_ADDR_INDEX 8'h14
`define CAU_ADDR_RESULT 8'h18
`define CAU_ADDR_STATUS 8'h1C

// control register fields
`define CAU_CTRL_OP_LSB 0
`define CAU_CTRL_PFX_LSB 8
`define CAU_CTRL_MEM_BIT 10
`define CAU_CTRL_IDX_BIT 11
`define CAU_CTRL_GO_BIT 16

// prefix selector codes
`define CAU_PFX_NONE 2'h0
`define CAU_PFX_BITS 2'h1
`define CAU_PFX_EXT 2'h2
`define CAU_PFX_INDEX 2'h3

// opcodes
`define CAU_OP_DECIMAL_ADJUST 8'h27
`define CAU_OP_INVERT_ACC 8'h2F
`define CAU_OP_TOGGLE_CARRY 8'h3F
`define CAU_OP_FORCE_CARRY 8'h37
`define CAU_OP_MASK_INT 8'hF3
`define CAU_OP_UNMASK_INT 8'hFB
`define CAU_OP_ACC_RLC 8'h07
`define CAU_OP_ACC_RRC 8'h0F
`define CAU_OP_ACC_RL 8'h17
`define CAU_OP_ACC_RR 8'h1F
`define CAU_OP_NEGATE 8'h44
`define CAU_OP_RESP_MODE0 8'h46
`define CAU_OP_RESP_MODE1 8'h56
`define CAU_OP_RESP_MODE2 8'h5E
`define CAU_OP_DIGIT_LEFT 8'h6F
`define CAU_OP_DIGIT_RIGHT 8'h67

// low opcode field of the 8-bit add-one / subtract-one
`define CAU_LOW_ADD_ONE 3'h4
`define CAU_LOW_SUB_ONE 3'h5

// top opcode field of the bit group
`define CAU_TOP_SHIFT 2'h0
`define CAU_TOP_TEST 2'h1
`define CAU_TOP_CLEAR 2'h2
`define CAU_TOP_FORCE 2'h3

// shift/rotate middle field codes
`define CAU_SH_RLC 3'h0
`define CAU_SH_RRC 3'h1
`define CAU_SH_RL 3'h2
`define CAU_SH_RR 3'h3
`define CAU_SH_SLA 3'h4
`define CAU_SH_SRA 3'h5
`define CAU_SH_SRL 3'h7

// T-state counts, one hclk per T state
`define CAU_T_SHORT 5'd4
`define CAU_T_PREFIXED 5'd8
`define CAU_T_WIDE_ADD 5'd11
`define CAU_T_INC_MEM 5'd11
`define CAU_T_BIT_MEM 5'd12
`define CAU_T_WIDE_INDEX 5'd15
`define CAU_T_SHIFT_MEM 5'd15
`define CAU_T_DIGIT 5'd18
`define CAU_T_BIT_IDX 5'd20
`define CAU_T_INDEXED 5'd23

// reset values
`define CAU_RST_FLAGS 8'h00
`define CAU_RST_MODE 2'h0

`endif

/* File: hw/cau_pkg.sv */
package cau_pkg;

   // flag byte, bit 7 down to bit 0
   typedef struct packed {
      logic s;
      logic z;
      logic y;
      logic h;
      logic x;
      logic p;
      logic n;
      logic c;
   } cau_flags_t;

   // everything one instruction changes, held until its last T state
   typedef struct packed {
      logic [7:0] acc;
      cau_flags_t flags;
      logic [7:0] data;
      logic [15:0] wide;
      logic to_ptr;
      logic to_idx;
      logic ien;
      logic [1:0] mode;
      logic ei_di;
      logic [4:0] tstates;
   } cau_result_t;

   typedef enum logic [0:0] {
      CAU_IDLE,
      CAU_RUN
   } cau_state_t;

endpackage : cau_pkg

/* File: hw/cau_exec.sv */
`timescale 1ns/1ps
`include "cau_defines.svh"
// Summary of operation
// - subtract-one mirrors add-one, sets N, carry kept
// - decimal adjust corrects accumulator to packed BCD
// - no interrupt sampling right after mask/unmask
// - mask clears, unmask sets interrupt enable flag
// - three extended opcodes select response mode 0-2
// - force carry and toggle carry flag effects
// - wide add to pointer pair, 11 T states
// - indexed wide add, index replaces pointer pair
// - accumulator rotate left circular, bit7 to carry
// - accumulator rotate right circular, bit0 to carry
// - prefixed rotate left circular sets S Z P
// - other shifts differ only in middle field
// - digit rotates move nibbles, 18 T states
// - digit rotates keep accumulator upper nibble
// - bit clear like bit force, top field 10

module cau_exec (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic interrupt_enable_flag,
   output logic [1:0] int_response_mode,
   output logic int_sample_ok
);

   // ==========================================================
   // bus slave
   // ==========================================================
   logic hreadyout_r;
   logic hresp_r;
   logic [31:0] hrdata_r;
   logic dphase_r;
   logic dwrite_r;
   logic [7:0] daddr_r;
   logic [31:0] rd_mux;
   logic wr_en;
   logic addr_ok;

   // working registers
   logic [7:0] acc_r;
   cau_pkg::cau_flags_t flags_r;
   logic [7:0] operand_r;
   logic [15:0] first_pair_r;
   logic [15:0] second_pair_r;
   logic [15:0] pointer_pair_r;
   logic [15:0] stack_pointer_r;
   logic [15:0] index_r;
   logic [11:0] ctrl_r;
   logic [15:0] result_r;
   logic iff_r;
   logic [1:0] mode_r;
   logic sample_ok_r;
   logic [4:0] last_t_r;

   // sequencing
   cau_pkg::cau_state_t state_r;
   cau_pkg::cau_result_t pend_r;
   cau_pkg::cau_result_t ex;
   logic [4:0] tcnt_r;
   logic start;
   logic commit;

   // fields of the instruction being written
   logic [7:0] op;
   logic [1:0] pfx;
   logic mem;
   logic idx;

   assign addr_ok = hsel & htrans[1] & hready;
   // one wait state on every transfer so read data leaves a flop
   assign wr_en = dphase_r & dwrite_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_r <= 1'b1;
         hresp_r <= 1'b0;
         hrdata_r <= 32'h0000_0000;
         dphase_r <= 1'b0;
         dwrite_r <= 1'b0;
         daddr_r <= 8'h00;
      end else if (addr_ok) begin
         hreadyout_r <= 1'b0;
         dphase_r <= 1'b1;
         dwrite_r <= hwrite;
         daddr_r <= haddr[7:0];
         hrdata_r <= hwrite ? 32'h0000_0000 : rd_mux;
      end else begin
         hreadyout_r <= 1'b1;
         dphase_r <= 1'b0;
         dwrite_r <= 1'b0;
      end
   end

   // read decode, unmapped addresses read zero
   always_comb begin
      case (haddr[7:0])
         `CAU_ADDR_CTRL: rd_mux = {20'h00000, ctrl_r};
         `CAU_ADDR_ACCFLG: rd_mux = {16'h0000, flags_r, acc_r};
         `CAU_ADDR_OPERAND: rd_mux = {24'h000000, operand_r};
         `CAU_ADDR_PAIRS: rd_mux = {second_pair_r, first_pair_r};
         `CAU_ADDR_PTRSTK: rd_mux = {stack_pointer_r, pointer_pair_r};
         `CAU_ADDR_INDEX: rd_mux = {16'h0000, index_r};
         `CAU_ADDR_RESULT: rd_mux = {16'h0000, result_r};
         `CAU_ADDR_STATUS: rd_mux = {19'h00000, last_t_r, 3'h0, sample_ok_r, mode_r, iff_r,
                                     (state_r == cau_pkg::CAU_RUN)};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // ==========================================================
   // execution
   // ==========================================================
   function automatic logic even_par(input logic [7:0] v);
      even_par = ~^v;
   endfunction : even_par

   // sign, zero and parity from a result byte
   function automatic cau_pkg::cau_flags_t szp(input cau_pkg::cau_flags_t f, input logic [7:0] v);
      cau_pkg::cau_flags_t o;
      o = f;
      o.s = v[7];
      o.z = (v == 8'h00);
      o.p = even_par(v);
      szp = o;
   endfunction : szp

   assign op = hwdata[`CAU_CTRL_OP_LSB +: 8];
   assign pfx = hwdata[`CAU_CTRL_PFX_LSB +: 2];
   assign mem = hwdata[`CAU_CTRL_MEM_BIT];
   assign idx = hwdata[`CAU_CTRL_IDX_BIT];
   assign start = wr_en && daddr_r == `CAU_ADDR_CTRL && hwdata[`CAU_CTRL_GO_BIT] &&
                  state_r == cau_pkg::CAU_IDLE;

   always_comb begin
      logic [7:0] src;
      logic [7:0] corr;
      logic [16:0] sum;
      logic [15:0] addend;
      ex = '0;
      ex.acc = acc_r;
      ex.flags = flags_r;
      ex.data = operand_r;
      ex.wide = pointer_pair_r;
      ex.ien = iff_r;
      ex.mode = mode_r;
      ex.tstates = (pfx == `CAU_PFX_NONE) ? `CAU_T_SHORT : `CAU_T_PREFIXED;
      src = (op[2:0] == 3'h7 && !mem && !idx) ? acc_r : operand_r;
      corr = 8'h00;
      sum = 17'h00000;
      addend = 16'h0000;
      case (pfx)
         `CAU_PFX_NONE, `CAU_PFX_INDEX: begin
            // wide add source by two-bit pair code
            case (op[5:4])
               2'h0: addend = first_pair_r;
               2'h1: addend = second_pair_r;
               2'h2: addend = (pfx == `CAU_PFX_INDEX) ? index_r : pointer_pair_r;
               default: addend = stack_pointer_r;
            endcase
            if (op[7:6] == 2'h0 && op[3:0] == 4'h9) begin
               sum = {1'b0, (pfx == `CAU_PFX_INDEX) ? index_r : pointer_pair_r} + {1'b0, addend};
               ex.wide = sum[15:0];
               ex.flags.n = 1'b0;
               ex.flags.c = sum[16];
               ex.to_ptr = (pfx == `CAU_PFX_NONE);
               ex.to_idx = (pfx == `CAU_PFX_INDEX);
               ex.tstates = (pfx == `CAU_PFX_INDEX) ? `CAU_T_WIDE_INDEX : `CAU_T_WIDE_ADD;
            end else if (pfx == `CAU_PFX_NONE && op[7:6] == 2'h0 &&
                         (op[2:0] == `CAU_LOW_ADD_ONE || op[2:0] == `CAU_LOW_SUB_ONE)) begin
               // shared forms and timing, carry untouched
               src = (op[5:3] == 3'h7 && !mem && !idx) ? acc_r : operand_r;
               if (op[2:0] == `CAU_LOW_SUB_ONE) begin
                  ex.data = src - 8'h01;
                  ex.flags.h = (src[3:0] == 4'h0);
                  ex.flags.n = 1'b1;
               end else begin
                  ex.data = src + 8'h01;
                  ex.flags.h = (src[3:0] == 4'hF);
                  ex.flags.n = 1'b0;
               end
               ex.flags = szp(ex.flags, ex.data);
               ex.flags.p = (op[2:0] == `CAU_LOW_SUB_ONE) ? (src == 8'h80) : (src == 8'h7F);
               if (op[5:3] == 3'h7 && !mem && !idx) begin
                  ex.acc = ex.data;
                  ex.data = operand_r;
               end
               ex.tstates = idx ? `CAU_T_INDEXED : (mem ? `CAU_T_INC_MEM : `CAU_T_SHORT);
            end else begin
               case (op)
                  `CAU_OP_DECIMAL_ADJUST: begin
                     if (flags_r.h || acc_r[3:0] > 4'h9) corr[3:0] = 4'h6;
                     if (flags_r.c || acc_r > 8'h99) begin
                        corr[7:4] = 4'h6;
                        ex.flags.c = 1'b1;
                     end
                     ex.acc = flags_r.n ? acc_r - corr : acc_r + corr;
                     ex.flags.h = flags_r.n ? (flags_r.h && acc_r[3:0] < 4'h6) : (acc_r[3:0] > 4'h9);
                     ex.flags = szp(ex.flags, ex.acc);
                  end
                  `CAU_OP_INVERT_ACC: begin
                     ex.acc = ~acc_r;
                     ex.flags.h = 1'b1;
                     ex.flags.n = 1'b1;
                  end
                  `CAU_OP_TOGGLE_CARRY: begin
                     // half carry left undefined; it takes the old carry
                     ex.flags.h = flags_r.c;
                     ex.flags.c = ~flags_r.c;
                     ex.flags.n = 1'b0;
                  end
                  `CAU_OP_FORCE_CARRY: begin
                     ex.flags.c = 1'b1;
                     ex.flags.h = 1'b0;
                     ex.flags.n = 1'b0;
                  end
                  `CAU_OP_MASK_INT: begin
                     ex.ien = 1'b0;
                     ex.ei_di = 1'b1;
                  end
                  `CAU_OP_UNMASK_INT: begin
                     ex.ien = 1'b1;
                     ex.ei_di = 1'b1;
                  end
                  `CAU_OP_ACC_RLC, `CAU_OP_ACC_RRC, `CAU_OP_ACC_RL, `CAU_OP_ACC_RR: begin
                     case (op)
                        `CAU_OP_ACC_RLC: ex.acc = {acc_r[6:0], acc_r[7]};
                        `CAU_OP_ACC_RRC: ex.acc = {acc_r[0], acc_r[7:1]};
                        `CAU_OP_ACC_RL: ex.acc = {acc_r[6:0], flags_r.c};
                        default: ex.acc = {flags_r.c, acc_r[7:1]};
                     endcase
                     ex.flags.c = op[3] ? acc_r[0] : acc_r[7];
                     ex.flags.h = 1'b0;
                     ex.flags.n = 1'b0;
                  end
                  default: ;
               endcase
            end
         end
         `CAU_PFX_EXT: begin
            case (op)
               `CAU_OP_NEGATE: begin
                  ex.acc = 8'h00 - acc_r;
                  ex.flags = szp(flags_r, ex.acc);
                  ex.flags.h = (acc_r[3:0] != 4'h0);
                  ex.flags.p = (acc_r == 8'h80);
                  ex.flags.n = 1'b1;
                  ex.flags.c = (acc_r != 8'h00);
               end
               `CAU_OP_RESP_MODE0: ex.mode = 2'h0;
               `CAU_OP_RESP_MODE1: ex.mode = 2'h1;
               `CAU_OP_RESP_MODE2: ex.mode = 2'h2;
               `CAU_OP_DIGIT_LEFT, `CAU_OP_DIGIT_RIGHT: begin
                  if (op == `CAU_OP_DIGIT_LEFT) begin
                     ex.data = {operand_r[3:0], acc_r[3:0]};
                     ex.acc = {acc_r[7:4], operand_r[7:4]};
                  end else begin
                     ex.data = {acc_r[3:0], operand_r[7:4]};
                     ex.acc = {acc_r[7:4], operand_r[3:0]};
                  end
                  ex.flags = szp(flags_r, ex.acc);
                  ex.flags.h = 1'b0;
                  ex.flags.n = 1'b0;
                  ex.tstates = `CAU_T_DIGIT;
               end
               default: ;
            endcase
         end
         default: begin
            // bit group: the operand byte, register or memory form
            case (op[7:6])
               `CAU_TOP_SHIFT: begin
                  case (op[5:3])
                     `CAU_SH_RLC: ex.data = {src[6:0], src[7]};
                     `CAU_SH_RRC: ex.data = {src[0], src[7:1]};
                     `CAU_SH_RL: ex.data = {src[6:0], flags_r.c};
                     `CAU_SH_RR: ex.data = {flags_r.c, src[7:1]};
                     `CAU_SH_SLA: ex.data = {src[6:0], 1'b0};
                     `CAU_SH_SRA: ex.data = {src[7], src[7:1]};
                     `CAU_SH_SRL: ex.data = {1'b0, src[7:1]};
                     default: ex.data = src; // unassigned code leaves the byte alone
                  endcase
                  ex.flags = szp(flags_r, ex.data);
                  ex.flags.h = 1'b0;
                  ex.flags.n = 1'b0;
                  ex.flags.c = op[3] ? src[0] : src[7];
                  ex.tstates = idx ? `CAU_T_INDEXED : (mem ? `CAU_T_SHIFT_MEM : `CAU_T_PREFIXED);
               end
               `CAU_TOP_TEST: begin
                  ex.data = operand_r; // no write back
                  ex.flags.z = ~src[op[5:3]];
                  ex.flags.h = 1'b1;
                  ex.flags.n = 1'b0;
                  ex.tstates = idx ? `CAU_T_BIT_IDX : (mem ? `CAU_T_BIT_MEM : `CAU_T_PREFIXED);
               end
               default: begin
                  ex.data = src;
                  ex.data[op[5:3]] = (op[7:6] == `CAU_TOP_FORCE);
                  ex.tstates = idx ? `CAU_T_INDEXED : (mem ? `CAU_T_SHIFT_MEM : `CAU_T_PREFIXED);
               end
            endcase
            if (op[7:6] != `CAU_TOP_TEST && op[2:0] == 3'h7 && !mem && !idx) begin
               ex.acc = ex.data;
            end
         end
      endcase
   end

   // sequencer: one hclk per T state, results land on the last one
   assign commit = (state_r == cau_pkg::CAU_RUN) && tcnt_r == 5'd1;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= cau_pkg::CAU_IDLE;
         tcnt_r <= 5'd0;
         pend_r <= '0;
         ctrl_r <= 12'h000;
      end else begin
         case (state_r)
            cau_pkg::CAU_IDLE: begin
               if (start) begin
                  state_r <= cau_pkg::CAU_RUN;
                  tcnt_r <= ex.tstates;
                  pend_r <= ex;
                  ctrl_r <= hwdata[11:0];
               end
            end
            cau_pkg::CAU_RUN: begin
               tcnt_r <= tcnt_r - 5'd1;
               if (commit) state_r <= cau_pkg::CAU_IDLE;
            end
            default: state_r <= cau_pkg::CAU_IDLE;
         endcase
      end
   end

   // working registers; software writes are ignored while running
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_r <= 8'h00;
         flags_r <= `CAU_RST_FLAGS;
         operand_r <= 8'h00;
         first_pair_r <= 16'h0000;
         second_pair_r <= 16'h0000;
         pointer_pair_r <= 16'h0000;
         stack_pointer_r <= 16'h0000;
         index_r <= 16'h0000;
         result_r <= 16'h0000;
         last_t_r <= 5'd0;
      end else if (commit) begin
         acc_r <= pend_r.acc;
         flags_r <= pend_r.flags;
         operand_r <= pend_r.data;
         result_r <= (pend_r.to_ptr || pend_r.to_idx) ? pend_r.wide : {8'h00, pend_r.data};
         last_t_r <= pend_r.tstates;
         if (pend_r.to_ptr) pointer_pair_r <= pend_r.wide;
         if (pend_r.to_idx) index_r <= pend_r.wide;
      end else if (wr_en && state_r == cau_pkg::CAU_IDLE) begin
         case (daddr_r)
            `CAU_ADDR_ACCFLG: begin
               acc_r <= hwdata[7:0];
               flags_r <= hwdata[15:8];
            end
            `CAU_ADDR_OPERAND: operand_r <= hwdata[7:0];
            `CAU_ADDR_PAIRS: begin
               first_pair_r <= hwdata[15:0];
               second_pair_r <= hwdata[31:16];
            end
            `CAU_ADDR_PTRSTK: begin
               pointer_pair_r <= hwdata[15:0];
               stack_pointer_r <= hwdata[31:16];
            end
            `CAU_ADDR_INDEX: index_r <= hwdata[15:0];
            default: ;
         endcase
      end
   end

   // interrupt control state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         iff_r <= 1'b0;
         mode_r <= `CAU_RST_MODE;
         sample_ok_r <= 1'b0;
      end else if (commit) begin
         iff_r <= pend_r.ien;
         mode_r <= pend_r.mode;
         // the instruction after mask/unmask must finish first
         sample_ok_r <= ~pend_r.ei_di;
      end
   end

   assign hreadyout = hreadyout_r;
   assign hresp = hresp_r;
   assign hrdata = hrdata_r;
   assign interrupt_enable_flag = iff_r;
   assign int_response_mode = mode_r;
   assign int_sample_ok = sample_ok_r;

endmodule : cau_exec

/* File: tb/cau_exec_assertions.sv */
`timescale 1ns/1ps
// ==========
// bus handshake and interrupt output checks
module cau_exec_checker (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic interrupt_enable_flag,
   input wire logic [1:0] int_response_mode,
   input wire logic int_sample_ok
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   logic take;
   // address phase accepted at this edge
   assign take = hsel & htrans[1] & hready;
   okay_resp_a: assert property (!hresp) else $error("non okay response");
   one_wait_a: assert property (take |=> !hreadyout ##1 hreadyout) else $error("wait state not one cycle");
   idle_ready_a: assert property (!take |=> hreadyout) else $error("wait state without transfer");
   read_hold_a: assert property ($fell(hreadyout) |=> $stable(hrdata)) else $error("read data moved early");
   unmapped_zero_a: assert property (take && !hwrite && haddr[7:5] != 3'h0 |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   // status must reflect the outputs as they stood at the address edge
   status_mirror_a: assert property (
      take && !hwrite && haddr[7:0] == 8'h1C |=>
      hrdata[4:1] == {$past(int_sample_ok), $past(int_response_mode), $past(interrupt_enable_flag)})
      else $error("status differs from outputs");
   iff_move_a: assert property ($changed(interrupt_enable_flag) |-> !int_sample_ok)
      else $error("enable flag moved with sampling open");
   mode_move_a: assert property ($changed(int_response_mode) |-> int_sample_ok)
      else $error("mode change closed sampling");
   mode_legal_a: assert property (int_response_mode != 2'h3)
      else $error("illegal response mode");
endmodule : cau_exec_checker

bind cau_exec cau_exec_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .interrupt_enable_flag(interrupt_enable_flag), .int_response_mode(int_response_mode),
   .int_sample_ok(int_sample_ok));

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, g;
   logic interrupt_enable_flag, int_sample_ok;
   logic [31:0] haddr, hwdata, hrdata, q, rnd, p1, p2;
   logic [1:0] htrans, int_response_mode;
   logic [2:0] hsize, b;
   logic [7:0] a, f, m, e;
   logic [8:0] r9;
   logic [15:0] hl, ix, src;
   logic [16:0] s17;
   logic [7:0] im_op [3] = '{8'h46, 8'h56, 8'h5E};
   int err_count, n_compared, cyc;

   cau_exec u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .interrupt_enable_flag(interrupt_enable_flag),
      .int_response_mode(int_response_mode), .int_sample_ok(int_sample_ok));
   // single slave, so its ready is the bus ready
   assign hready = hreadyout;

   // ==========
   // clock and hang guard
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 40000) begin
         err_count++;
         $display("ERROR %0t: run did not finish", $time);
         results;
      end
   end

   // ==========
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [7:0] fl(input logic s, z, h, p, n, c);
      return {s, z, 1'b0, h, 1'b0, p, n, c};
   endfunction : fl
   function automatic logic [7:0] fr(input logic [7:0] r, input logic h, n, c);
      return fl(r[7], r == 8'h0, h, ~^r, n, c);
   endfunction : fr
   // carry out on top, shifted byte below
   function automatic logic [8:0] shf(input logic [2:0] k, input logic [7:0] v, input logic ci);
      case (k)
         3'h0: return {v[7], v[6:0], v[7]};
         3'h1: return {v[0], v[0], v[7:1]};
         3'h2: return {v[7], v[6:0], ci};
         3'h3: return {v[0], ci, v[7:1]};
         3'h4: return {v[7], v[6:0], 1'b0};
         3'h5: return {v[0], v[7], v[7:1]};
         default: return {v[0], 1'b0, v[7:1]};
      endcase
   endfunction : shf
   task automatic nxt;
      repeat (32) rnd = lfsr(rnd);
   endtask : nxt
   task automatic chk(input logic [31:0] gv, input logic [31:0] ev, input logic [31:0] k);
      n_compared++;
      if ((gv & k) !== (ev & k)) begin
         err_count++;
         $display("ERROR %0t: got %h expected %h", $time, gv & k, ev & k);
      end
   endtask : chk
   // ready and read data are taken at the rising edge
   task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] rq);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, ad};
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rq = hrdata;
   endtask : xfer
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      xfer(1'b1, ad, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] ad, output logic [31:0] d);
      xfer(1'b0, ad, 32'h0, d);
   endtask : rd
   // load state, start one instruction, wait for it, check timing, accumulator, flags and operand
   task automatic ex(input logic [15:0] af, input logic [7:0] od, input logic [11:0] ctl, input logic [4:0] t,
      input logic [15:0] eaf, input logic [7:0] fm, input logic [7:0] eo);
      wr(8'h04, {16'h0, af});
      wr(8'h08, {24'h0, od});
      wr(8'h00, {15'h0, 1'b1, 4'h0, ctl});
      do rd(8'h1C, q); while (q[0] !== 1'b0);
      chk(q, {19'h0, t, 8'h0}, 32'h1F00);
      rd(8'h04, q);
      chk(q, {16'h0, eaf}, {16'h0, fm, 8'hFF});
      rd(8'h08, q);
      chk(q, {24'h0, eo}, 32'hFF);
   endtask : ex
   task automatic results;
      $display("comparisons %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results

   // ==========
   // main sequence
   initial begin
      hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
      hsize = 3'h2; hwdata = 32'h0; rnd = 32'd96830; err_count = 0; n_compared = 0; cyc = 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(8'h1C, q);
      chk(q, 32'h0, 32'hFFFFFFFF);
      rd(8'h04, q);
      chk(q, 32'h0, 32'hFFFFFFFF);
      rd(8'h40, q);
      chk(q, 32'h0, 32'hFFFFFFFF);
      for (int i = 0; i < 8; i++) begin
         nxt;
         a = (i == 0) ? 8'h80 : (i == 1) ? 8'h00 : rnd[7:0];
         f = rnd[15:8];
         m = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : rnd[23:16];
         b = rnd[26:24];
         ex({f, a}, m, 12'h0F3, 5'd4, {f, a}, 8'hD7, m);
         chk({31'h0, interrupt_enable_flag, int_sample_ok}, 32'h0, 32'h3);
         ex({f, a}, m, 12'h0FB, 5'd4, {f, a}, 8'hD7, m);
         chk({31'h0, interrupt_enable_flag, int_sample_ok}, 32'h2, 32'h3);
         ex({f, a}, m, 12'h000, 5'd4, {f, a}, 8'hD7, m);
         chk({31'h0, int_sample_ok}, 32'h1, 32'h1);
         for (int k = 0; k < 3; k++) begin
            ex({f, a}, m, {4'h2, im_op[k]}, 5'd8, {f, a}, 8'hD7, m);
            chk({30'h0, int_response_mode}, 32'(k), 32'h3);
         end
         ex({f, a}, m, 12'h037, 5'd4, {fl(f[7], f[6], 1'b0, f[2], 1'b0, 1'b1), a}, 8'hD7, m);
         ex({f, a}, m, 12'h03F, 5'd4, {fl(f[7], f[6], 1'b0, f[2], 1'b0, ~f[0]), a}, 8'hC7, m);
         ex({f, a}, m, 12'h007, 5'd4, {fl(f[7], f[6], 1'b0, f[2], 1'b0, a[7]), a[6:0], a[7]}, 8'hD7, m);
         ex({f, a}, m, 12'h00F, 5'd4, {fl(f[7], f[6], 1'b0, f[2], 1'b0, a[0]), a[0], a[7:1]}, 8'hD7, m);
         e = a - 8'h1;
         ex({f, a}, m, 12'h03D, 5'd4, {fl(e[7], e == 8'h0, a[3:0] == 4'h0, a == 8'h80, 1'b1, f[0]), e}, 8'hD7, m);
         e = a + 8'h1;
         ex({f, a}, m, 12'h03C, 5'd4, {fl(e[7], e == 8'h0, a[3:0] == 4'hF, a == 8'h7F, 1'b0, f[0]), e}, 8'hD7, m);
         e = m - 8'h1;
         ex({f, a}, m, 12'h435, 5'd11, {fl(e[7], e == 8'h0, m[3:0] == 4'h0, m == 8'h80, 1'b1, f[0]), a}, 8'hD7, e);
         for (int k = 0; k < 8; k++) begin
            g = rnd[k];
            r9 = shf(k[2:0], m, f[0]);
            if (k != 6)
               ex({f, a}, m, {1'b0, g, 4'h4, k[2:0], g ? 3'h6 : 3'h0}, g ? 5'd15 : 5'd8,
                  {fr(r9[7:0], 1'b0, 1'b0, r9[8]), a}, 8'hD7, r9[7:0]);
         end
         ex({f, a}, m, {6'h5, b, 3'h0}, 5'd8, {fl(f[7], ~m[b], 1'b1, f[2], 1'b0, f[0]), a}, 8'hD7, m);
         ex({f, a}, m, {6'h7, b, 3'h0}, 5'd8, {f, a}, 8'hD7, m | (8'h1 << b));
         ex({f, a}, m, {6'h6, b, 3'h0}, 5'd8, {f, a}, 8'hD7, m & ~(8'h1 << b));
         ex({f, a}, m, 12'h26F, 5'd18, {fr({a[7:4], m[7:4]}, 1'b0, 1'b0, f[0]), a[7:4], m[7:4]}, 8'hD7,
            {m[3:0], a[3:0]});
         ex({f, a}, m, 12'h267, 5'd18, {fr({a[7:4], m[3:0]}, 1'b0, 1'b0, f[0]), a[7:4], m[3:0]}, 8'hD7,
            {a[3:0], m[7:4]});
         ex({f, a}, m, 12'h02F, 5'd4, {fl(f[7], f[6], 1'b1, f[2], 1'b1, f[0]), ~a}, 8'hD7, m);
         e = 8'h0 - a;
         ex({f, a}, m, 12'h244, 5'd8, {fl(e[7], e == 8'h0, a[3:0] != 4'h0, a == 8'h80, 1'b1, a != 8'h0), e},
            8'hD7, m);
         // wide add rewrites its destination, so reload sources
         nxt;
         wr(8'h0C, rnd);
         p1 = rnd;
         for (int k = 0; k < 8; k++) begin
            nxt;
            p2 = rnd;
            ix = rnd[15:0] ^ rnd[31:16];
            wr(8'h10, p2);
            wr(8'h14, {16'h0, ix});
            hl = k[2] ? ix : p2[15:0];
            src = (k[1:0] == 2'h0) ? p1[15:0] : (k[1:0] == 2'h1) ? p1[31:16] : (k[1:0] == 2'h2) ? hl : p2[31:16];
            s17 = {1'b0, hl} + {1'b0, src};
            ex({f, a}, m, {2'h0, k[2] ? 2'h3 : 2'h0, 2'h0, k[1:0], 4'h9}, k[2] ? 5'd15 : 5'd11,
               {fl(f[7], f[6], 1'b0, f[2], 1'b0, s17[16]), a}, 8'hC7, m);
            rd(8'h18, q);
            chk(q, {16'h0, s17[15:0]}, 32'hFFFF);
         end
         $display("round %0d done", i);
      end
      ex(16'h000F, m, 12'h027, 5'd4, 16'h0015, 8'hC7, m);
      ex(16'h009A, m, 12'h027, 5'd4, 16'h4500, 8'hC7, m);
      ex(16'h0242, m, 12'h027, 5'd4, 16'h0642, 8'hC7, m);
      $display("decimal adjust corners done");
      results;
   end
endmodule : tb_top
